// ---- logic/sdp_pkg.sv ----
// sdp_pkg: constants, types and register map of the serial config bank
// assumes one 125 MHz core clock; serial pins arrive asynchronously
package sdp_pkg;

    // ****************************************************************
    // serial addresses and sizes
    // ****************************************************************
    localparam int          ADDR_W            = 5;
    localparam logic [4:0]  ADDR_CW1          = 5'h00;
    localparam logic [4:0]  ADDR_CW2          = 5'h01;
    localparam logic [4:0]  ADDR_AMP          = 5'h02;
    localparam logic [4:0]  ADDR_RMP          = 5'h03;
    localparam logic [4:0]  ADDR_FTW          = 5'h04;
    localparam logic [4:0]  ADDR_POW          = 5'h05;
    localparam logic [5:0]  BITS_CW1          = 6'd32;
    localparam logic [5:0]  BITS_CW2          = 6'd24;
    localparam logic [5:0]  BITS_AMP          = 6'd16;
    localparam logic [5:0]  BITS_RMP          = 6'd8;
    localparam logic [5:0]  BITS_FTW          = 6'd32;
    localparam logic [5:0]  BITS_POW          = 6'd16;
    localparam logic [5:0]  BITS_UNMAPPED     = 6'd8;
    localparam logic [5:0]  BITS_INSTR        = 6'd8;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          INSTR_RD_BIT      = 7;
    localparam int          CW1_LSB_FIRST_BIT = 8;
    localparam int          CW1_IN_ONLY_BIT   = 9;
    localparam int          CW2_MULT_LO       = 3;
    localparam int          AMP_SPEED_LO      = 14;
    localparam logic [4:0]  MULT_MIN          = 5'h04;
    localparam logic [4:0]  MULT_MAX          = 5'h14;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [31:0] RST_CW1           = 32'h0000_0000;
    localparam logic [23:0] RST_CW2           = 24'h00_0000;
    localparam logic [15:0] RST_AMP           = 16'h0000;
    localparam logic [7:0]  RST_RMP           = 8'h00;
    localparam logic [31:0] RST_FTW           = 32'h0000_0000;
    localparam logic [15:0] RST_POW           = 16'h0000;
    // synchroniser stages: select idles high, the rest low
    localparam logic [3:0]  RST_PINS          = 4'h4;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [31:0] cw1;
        logic [23:0] cw2;
        logic [15:0] amp;
        logic [7:0]  rmp;
        logic [31:0] ftw;
        logic [15:0] pow;
    } sdp_regs_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic io_sync;
        logic sdi;
    } sdp_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b11
    } sdp_state_t;

endpackage : sdp_pkg

// ---- logic/sdp_pin_sync.sv ----
// sdp_pin_sync: three-flop synchroniser with agreement filter per bit
// assumes inputs are asynchronous to mclk_in
`timescale 1ns/10ps
module sdp_pin_sync #(
    parameter int             W       = 4,
    parameter logic [W-1:0]   RST_VAL = '0  // idle level of each pin
) (
    input  wire logic         mclk_in,   // core clock
    input  wire logic         rst_n_in,  // async reset, low active
    input  wire logic [W-1:0] async_in,  // raw pin levels
    output logic      [W-1:0] sync_out   // filtered levels
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // change only counts once stages two and three agree
            always_comb begin
                out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
            end
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_r[g]  <= RST_VAL[g];
                    s2_r[g]  <= RST_VAL[g];
                    s3_r[g]  <= RST_VAL[g];
                    out_r[g] <= RST_VAL[g];
                end else begin
                    s1_r[g]  <= async_in[g];
                    s2_r[g]  <= s1_r[g];
                    s3_r[g]  <= s2_r[g];
                    out_r[g] <= out_nxt[g];
                end
            end
        end
    endgenerate

    assign sync_out = out_r;

endmodule : sdp_pin_sync

// ---- logic/sdp_serial_bank.sv ----
// sdp_serial_bank: serial control port and six configuration registers
// assumes sclk is far slower than mclk_in (at least 8 core cycles/phase)
`timescale 1ns/10ps

// Operation
// - host may read and write every register
// - both MSB-first and LSB-first transfers work
// - control_word_one bit 8 selects LSB first
// - two-wire shared pin or three-wire separate pins
// - control_word_one bit 9 makes data pin input-only
// - optional io sync and chip select inputs
// - serial addresses 00h to 05h select registers
// - ramp rate is 8 bits at 03h
// - amplitude scale low bits, speed field on top
// - multiplier 4..20 multiplies, else bypass
module sdp_serial_bank
    import sdp_pkg::*;
(
    input  wire logic       mclk_in,         // core clock 125 MHz
    input  wire logic       rst_n_in,        // async reset, low active
    input  wire logic       sclk_in,         // serial clock pin
    input  wire logic       chip_select_n_in,// chip select, low active
    input  wire logic       io_sync_in,      // high aborts the transfer
    input  wire logic       sdio_in,         // data pin, input side
    output logic            sdio_out,        // data pin, output side
    output logic            sdio_oe_out,     // data pin drive enable
    output logic            serial_data_out_pin_out, // 3-wire read data
    output sdp_regs_t       regs_out,        // register contents
    output logic            pll_bypass_out,  // multiplier bypassed
    output logic [1:0]      ramp_speed_out   // auto ramp speed field
);

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    sdp_pins_t pin_raw;
    sdp_pins_t pin_s;
    logic [3:0] pin_vec;

    assign pin_raw = '{sclk: sclk_in, cs_n: chip_select_n_in,
                       io_sync: io_sync_in, sdi: sdio_in};

    // select resets to its idle level: no false frame after reset
    sdp_pin_sync #(.W(4), .RST_VAL(RST_PINS)) u_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .async_in (pin_raw),
        .sync_out (pin_vec)
    );
    assign pin_s = sdp_pins_t'(pin_vec);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [4:0] bit_idx(input logic       lsb,
                                           input logic [5:0] cnt,
                                           input logic [5:0] nbits);
        logic [5:0] t;
        t = lsb ? cnt : (nbits - 6'd1 - cnt);
        return t[4:0];
    endfunction : bit_idx

    function automatic logic [5:0] reg_bits(input logic [4:0] a);
        case (a)
            ADDR_CW1: reg_bits = BITS_CW1;
            ADDR_CW2: reg_bits = BITS_CW2;
            ADDR_AMP: reg_bits = BITS_AMP;
            ADDR_RMP: reg_bits = BITS_RMP;
            ADDR_FTW: reg_bits = BITS_FTW;
            ADDR_POW: reg_bits = BITS_POW;
            default:  reg_bits = BITS_UNMAPPED;
        endcase
    endfunction : reg_bits

    function automatic logic [31:0] read_word(input sdp_regs_t r,
                                              input logic [4:0] a);
        case (a)
            ADDR_CW1: read_word = r.cw1;
            ADDR_CW2: read_word = {8'h00, r.cw2};
            ADDR_AMP: read_word = {16'h0000, r.amp};
            ADDR_RMP: read_word = {24'h00_0000, r.rmp};
            ADDR_FTW: read_word = r.ftw;
            ADDR_POW: read_word = {16'h0000, r.pow};
            default:  read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // ****************************************************************
    // serial engine and register file
    // ****************************************************************
    sdp_state_t  state_r,  state_nxt;
    logic [5:0]  cnt_r,    cnt_nxt;
    logic [5:0]  nbits_r,  nbits_nxt;
    logic [7:0]  instr_r,  instr_nxt;
    logic [31:0] wdat_r,   wdat_nxt;
    logic [31:0] rdat_r,   rdat_nxt;
    logic [4:0]  addr_r,   addr_nxt;
    logic        rd_r,     rd_nxt;
    logic        obit_r,   obit_nxt;
    logic        sclk_d_r;
    logic        bypass_r, bypass_nxt;
    logic [1:0]  speed_r,  speed_nxt;
    sdp_regs_t   regs_r,   regs_nxt;
    logic        rise, fall, lsb, three_wire, commit;
    logic [7:0]  instr_tmp;
    logic [31:0] wdat_tmp;
    logic [4:0]  mult;
    logic [4:0]  ibit;

    assign rise       = pin_s.sclk & ~sclk_d_r;
    assign fall       = ~pin_s.sclk & sclk_d_r;
    assign lsb        = regs_r.cw1[CW1_LSB_FIRST_BIT];
    assign three_wire = regs_r.cw1[CW1_IN_ONLY_BIT];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        nbits_nxt = nbits_r;
        instr_nxt = instr_r;
        wdat_nxt  = wdat_r;
        rdat_nxt  = rdat_r;
        addr_nxt  = addr_r;
        rd_nxt    = rd_r;
        obit_nxt  = obit_r;
        regs_nxt  = regs_r;
        commit    = 1'b0;
        instr_tmp = instr_r;
        wdat_tmp  = wdat_r;
        ibit      = bit_idx(lsb, cnt_r, BITS_INSTR);
        // either optional pin ends a transfer; both may be tied off
        if (pin_s.cs_n || pin_s.io_sync) begin
            state_nxt = ST_IDLE;
            cnt_nxt   = 6'd0;
            obit_nxt  = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_INSTR;
                    cnt_nxt   = 6'd0;
                end
                ST_INSTR: begin
                    if (rise) begin
                        instr_tmp[ibit[2:0]] = pin_s.sdi;
                        instr_nxt = instr_tmp;
                        if (cnt_r == BITS_INSTR - 6'd1) begin
                            addr_nxt  = instr_tmp[4:0];
                            rd_nxt    = instr_tmp[INSTR_RD_BIT];
                            nbits_nxt = reg_bits(instr_tmp[4:0]);
                            rdat_nxt  = read_word(regs_r,
                                                  instr_tmp[4:0]);
                            wdat_nxt  = 32'h0000_0000;
                            cnt_nxt   = 6'd0;
                            state_nxt = ST_DATA;
                        end else begin
                            cnt_nxt = cnt_r + 6'd1;
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        if (!rd_r) begin
                            wdat_tmp[bit_idx(lsb, cnt_r, nbits_r)]
                                = pin_s.sdi;
                            wdat_nxt = wdat_tmp;
                        end
                        if (cnt_r == nbits_r - 6'd1) begin
                            commit    = ~rd_r;
                            cnt_nxt   = 6'd0;
                            state_nxt = ST_INSTR;
                        end else begin
                            cnt_nxt = cnt_r + 6'd1;
                        end
                    end else if (fall && rd_r) begin
                        // read bit launched on falling edge
                        obit_nxt = rdat_r[bit_idx(lsb, cnt_r, nbits_r)];
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
        if (commit) begin
            case (addr_r)
                ADDR_CW1: regs_nxt.cw1 = wdat_tmp;
                ADDR_CW2: regs_nxt.cw2 = wdat_tmp[23:0];
                ADDR_AMP: regs_nxt.amp = wdat_tmp[15:0];
                ADDR_RMP: regs_nxt.rmp = wdat_tmp[7:0];
                ADDR_FTW: regs_nxt.ftw = wdat_tmp;
                ADDR_POW: regs_nxt.pow = wdat_tmp[15:0];
                default:  regs_nxt = regs_r;
            endcase
        end
        mult       = regs_r.cw2[CW2_MULT_LO +: 5];
        bypass_nxt = (mult < MULT_MIN) || (mult > MULT_MAX);
        speed_nxt  = regs_r.amp[AMP_SPEED_LO +: 2];
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 6'd0;
            nbits_r  <= BITS_UNMAPPED;
            instr_r  <= 8'h00;
            wdat_r   <= 32'h0000_0000;
            rdat_r   <= 32'h0000_0000;
            addr_r   <= 5'h00;
            rd_r     <= 1'b0;
            obit_r   <= 1'b0;
            sclk_d_r <= 1'b0;
            bypass_r <= 1'b1;
            speed_r  <= 2'b00;
            regs_r   <= '{cw1: RST_CW1, cw2: RST_CW2, amp: RST_AMP,
                          rmp: RST_RMP, ftw: RST_FTW, pow: RST_POW};
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            nbits_r  <= nbits_nxt;
            instr_r  <= instr_nxt;
            wdat_r   <= wdat_nxt;
            rdat_r   <= rdat_nxt;
            addr_r   <= addr_nxt;
            rd_r     <= rd_nxt;
            obit_r   <= obit_nxt;
            sclk_d_r <= pin_s.sclk;
            bypass_r <= bypass_nxt;
            speed_r  <= speed_nxt;
            regs_r   <= regs_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // shared pin only turned round in two-wire mode during a read
    assign sdio_oe_out = (state_r == ST_DATA) && rd_r
                         && !three_wire;
    assign sdio_out    = obit_r;
    assign serial_data_out_pin_out = three_wire ? obit_r : 1'b0;
    assign regs_out       = regs_r;
    assign pll_bypass_out = bypass_r;
    assign ramp_speed_out = speed_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_OE_ONLY_READ: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        sdio_oe_out |-> (state_r == ST_DATA) && rd_r && !three_wire)
        else $error("data pin driven outside a two-wire read");

    AST_THREE_WIRE_QUIET: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        three_wire |-> !sdio_oe_out)
        else $error("data pin driven in three-wire mode");

    AST_FTW_WRITE: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        commit && addr_r == ADDR_FTW |=> regs_r.ftw == $past(wdat_tmp))
        else $error("tuning word not written");

    AST_ONLY_ADDRESSED: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        commit && addr_r != ADDR_FTW |=> $stable(regs_r.ftw))
        else $error("write touched another register");

    AST_RMP_WIDTH: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        state_r == ST_DATA && addr_r == ADDR_RMP |-> nbits_r == BITS_RMP)
        else $error("ramp rate transfer not eight bits");

    AST_BYPASS: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        ($past(regs_r.cw2[7:3]) > MULT_MAX
         || $past(regs_r.cw2[7:3]) < MULT_MIN) |-> pll_bypass_out)
        else $error("multiplier not bypassed");

    AST_SPEED: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        ramp_speed_out == $past(regs_r.amp[AMP_SPEED_LO +: 2]))
        else $error("ramp speed field mismatch");

    AST_LSB_FIRST: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        state_r == ST_INSTR && rise && cnt_r == 6'd0 && lsb
        && !pin_s.cs_n && !pin_s.io_sync |=> instr_r[0] == $past(pin_s.sdi))
        else $error("first bit not placed at bit zero");

    AST_ABORT: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        pin_s.cs_n |=> state_r == ST_IDLE && !sdio_oe_out)
        else $error("transfer continued with select high");

endmodule : sdp_serial_bank

// ---- test/sdp_host_model.sv ----
// sdp_host_model: host side of the serial control port, behavioural
// assumes mclk_in paces every pin change; sclk idles low outside frames
`timescale 1ns/10ps
module sdp_host_model (
    input  wire logic mclk_in,           // core clock, pacing only
    input  wire logic sdio_in,           // resolved shared data pin
    input  wire logic serial_data_out_pin_in, // three-wire read pin
    input  wire logic oe_in,             // device drive enable
    output logic      sclk_out,          // serial clock
    output logic      chip_select_n_out, // select, low active
    output logic      io_sync_out,       // abort, high active
    output logic      data_out           // host drive of data pin
);
    // ****************************************************************
    // pacing
    // ****************************************************************
    int half = 10;  // mclk cycles per sclk phase, 160 ns period

    initial begin
        sclk_out = 1'b0;
        chip_select_n_out = 1'b1;
        io_sync_out = 1'b0;
        data_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : tick

    // ****************************************************************
    // one transfer; cut > 0 abandons it after that many data bits
    // ****************************************************************
    task automatic xfer(input logic rd, input logic [4:0] addr,
                        input int nbits, input logic [31:0] wdata,
                        input logic lsb, input logic three, input int cut,
                        input logic by_sync, output logic [31:0] rdata,
                        output logic [31:0] roe);
        logic [7:0] ins;
        int         i;
        int         k;
        ins = {rd, 2'b00, addr};
        rdata = '0;
        roe = '0;
        @(posedge mclk_in);
        chip_select_n_out <= 1'b0;
        for (i = 0; i < 8 + nbits; i++) begin
            if (cut != 0 && i == 8 + cut) begin
                if (by_sync) io_sync_out <= 1'b1;
                else chip_select_n_out <= 1'b1;
                break;
            end
            if (i < 8) begin
                k = lsb ? i : 7 - i;
                data_out <= ins[k];
            end else begin
                k = lsb ? i - 8 : nbits - 1 - (i - 8);
                // released line must not look like the last bit
                data_out <= rd ? ~data_out : wdata[k];
            end
            tick(half);
            if (rd && i >= 8) begin
                rdata[k] = three ? serial_data_out_pin_in : sdio_in;
                roe[k] = oe_in;
            end
            sclk_out <= 1'b1;
            tick(half);
            sclk_out <= 1'b0;
        end
        tick(half);
        io_sync_out <= 1'b0;
        chip_select_n_out <= 1'b1;
        tick(half);
    endtask : xfer
endmodule : sdp_host_model

// ---- test/sdp_serial_bank_test.sv ----
// sdp_serial_bank_test: register access through the serial port
// assumes sdp_pkg, sdp_serial_bank and sdp_host_model are compiled
`timescale 1ns/10ps
module sdp_serial_bank_test;
    import sdp_pkg::*;
    logic       mclk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       sclk, cs_n, io_sync, host_sdio, dev_sdio, dev_oe, read_pin;
    logic       pll_bypass;
    logic [1:0] ramp_speed;
    sdp_regs_t  regs, exp_regs;
    wire logic  sdio_wire;
    int         failures = 0;
    int         check_count = 0;
    logic       lsb_mode = 1'b0;
    logic       three_mode = 1'b0;
    logic [31:0] vals [6] = '{32'h8421_00F1, 32'h00A5_5A20, 32'h0000_C0DE,
                              32'h0000_00A7, 32'hF00D_BEEF, 32'h0000_3ABC};
    logic [4:0]  mults [5] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h1F};

    assign sdio_wire = dev_oe ? dev_sdio : host_sdio;
    always #4 mclk_in = ~mclk_in;

    sdp_serial_bank DUT (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .chip_select_n_in(cs_n), .io_sync_in(io_sync),
        .sdio_in(sdio_wire), .sdio_out(dev_sdio), .sdio_oe_out(dev_oe),
        .serial_data_out_pin_out(read_pin), .regs_out(regs),
        .pll_bypass_out(pll_bypass), .ramp_speed_out(ramp_speed));
    sdp_host_model host (
        .mclk_in(mclk_in), .sdio_in(sdio_wire),
        .serial_data_out_pin_in(read_pin),
        .oe_in(dev_oe), .sclk_out(sclk), .chip_select_n_out(cs_n),
        .io_sync_out(io_sync), .data_out(host_sdio));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : tick

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    function automatic int width_of(input logic [4:0] a);
        case (a)
            ADDR_CW1: return int'(BITS_CW1);
            ADDR_CW2: return int'(BITS_CW2);
            ADDR_AMP: return int'(BITS_AMP);
            ADDR_RMP: return int'(BITS_RMP);
            ADDR_FTW: return int'(BITS_FTW);
            ADDR_POW: return int'(BITS_POW);
            default:  return int'(BITS_UNMAPPED);
        endcase
    endfunction : width_of

    function automatic logic [31:0] field(input logic [4:0] a);
        case (a)
            ADDR_CW1: return exp_regs.cw1;
            ADDR_CW2: return {8'h00, exp_regs.cw2};
            ADDR_AMP: return {16'h0000, exp_regs.amp};
            ADDR_RMP: return {24'h00_0000, exp_regs.rmp};
            ADDR_FTW: return exp_regs.ftw;
            ADDR_POW: return {16'h0000, exp_regs.pow};
            default:  return 32'h0000_0000;
        endcase
    endfunction : field

    // write, then compare every register; cut > 0 aborts mid-data
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input int cut = 0, input logic by_sync = 1'b0);
        logic [31:0] r, o;
        host.xfer(1'b0, a, width_of(a), d, lsb_mode, three_mode, cut,
                  by_sync, r, o);
        if (cut == 0) begin
            case (a)
                ADDR_CW1: exp_regs.cw1 = d;
                ADDR_CW2: exp_regs.cw2 = d[23:0];
                ADDR_AMP: exp_regs.amp = d[15:0];
                ADDR_RMP: exp_regs.rmp = d[7:0];
                ADDR_FTW: exp_regs.ftw = d;
                ADDR_POW: exp_regs.pow = d[15:0];
                default:  ;
            endcase
            if (a == ADDR_CW1) begin
                lsb_mode = d[CW1_LSB_FIRST_BIT];
                three_mode = d[CW1_IN_ONLY_BIT];
            end
        end
        tick(8);
        check("regs_out", regs, exp_regs);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        logic [31:0] r, o, m;
        int          n;
        n = width_of(a);
        m = (n == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << n) - 1;
        host.xfer(1'b1, a, n, 32'h0000_0000, lsb_mode, three_mode, 0,
                  1'b0, r, o);
        check("read data", {96'h0, r}, {96'h0, field(a)});
        check("data pin enable", {96'h0, o},
              {96'h0, three_mode ? 32'h0000_0000 : m});
    endtask : rd

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        #400_000; // about twice the expected run
        failures++;
        close_out();
    end

    initial begin
        exp_regs = '0;
        tick(12);
        rst_n_in <= 1'b1;
        tick(8);
        check("reset regs", regs, exp_regs);
        check("reset bypass", {127'h0, pll_bypass}, {127'h0, 1'b1});
        for (int a = 0; a < 6; a++) wr(5'(a), vals[a]);
        check("speed", {126'h0, ramp_speed}, {126'h0, 2'b11});
        for (int a = 0; a < 6; a++) rd(5'(a));
        wr(ADDR_AMP, 32'h0000_4123);
        check("speed", {126'h0, ramp_speed}, {126'h0, 2'b01});
        foreach (mults[i]) begin
            wr(ADDR_CW2, {8'h00, 16'h00A5, mults[i], 3'b000});
            check("bypass", {127'h0, pll_bypass}, {127'h0,
                  mults[i] < MULT_MIN || mults[i] > MULT_MAX});
        end
        // unmapped places take nothing and read as zero
        wr(5'h06, 32'h0000_00FF);
        rd(5'h1F);
        wr(ADDR_FTW, 32'h1234_5678, 12, 1'b1);
        wr(ADDR_POW, 32'h0000_7777, 5, 1'b0);
        rd(ADDR_FTW);
        wr(ADDR_CW1, 32'h8421_01F1);
        wr(ADDR_POW, 32'h0000_1E2D);
        rd(ADDR_POW);
        host.half = 14;
        wr(ADDR_RMP, 32'h0000_005C);
        host.half = 10;
        rd(ADDR_RMP);
        wr(ADDR_CW1, 32'h8421_03F1);
        rd(ADDR_FTW);
        wr(ADDR_CW1, 32'h8421_02F1);
        rd(ADDR_AMP);
        wr(ADDR_CW1, 32'h0000_0000);
        rd(ADDR_CW2);
        rst_n_in <= 1'b0;
        tick(3);
        exp_regs = '0;
        lsb_mode = 1'b0;
        three_mode = 1'b0;
        check("mid reset regs", regs, exp_regs);
        rst_n_in <= 1'b1;
        tick(8);
        rd(ADDR_FTW);
        close_out();
    end
endmodule : sdp_serial_bank_test
